//--- prio_capt_pkg.sv
/*
 * Shared constants for the partition priority and capture trigger register block.
 * Assumes register offsets are byte offsets within each 4 KB security-space frame.
 */
package prio_capt_pkg;

   typedef enum logic [1:0] {
      SPACE_SECURE = 2'h0,
      SPACE_NONSECURE = 2'h1,
      SPACE_ROOT = 2'h2,
      SPACE_REALM = 2'h3
   } space_t;

   localparam int NUM_SPACES = 4;
   localparam int OFFSET_W = 12;

   localparam logic [11:0] OFF_ERR_STATUS = 12'h0f0;
   localparam logic [11:0] OFF_PART_SEL = 12'h100;
   localparam logic [11:0] OFF_PRI = 12'h400;
   localparam logic [11:0] OFF_MONITOR_INDEX = 12'h800;
   localparam logic [11:0] OFF_CAPT = 12'h808;
   localparam logic [11:0] OFF_CSU_CTL = 12'h810;

   localparam int SEL_RIS_LSB = 24;
   localparam int SEL_RIS_W = 4;
   localparam int SEL_INTERNAL_BIT = 16;
   localparam int SEL_ID_W = 16;

   localparam int PRI_DS_LSB = 16;
   localparam int PRI_FIELD_W = 16;

   localparam int CAPT_FIRE_BIT = 0;
   localparam int CAPT_BCAST_BIT = 1;

   localparam int CSU_EN_BIT = 31;
   localparam int CSU_CAPT_LSB = 28;
   localparam int CSU_MATCH_PMG_BIT = 17;
   localparam int CSU_MATCH_PART_BIT = 16;
   localparam logic [2:0] CAPT_SRC_LOCAL = 3'h7;
   localparam logic [7:0] CSU_TYPE_CODE = 8'h43;

   localparam int ERR_INTERNAL_BIT = 0;
   localparam int ERR_RANGE_BIT = 1;

   localparam logic [31:0] SEL_RST = 32'h0000_0000;
   localparam logic [5:0] CSU_RST = 6'h00;
   localparam logic [1:0] ERR_RST = 2'h0;

endpackage : prio_capt_pkg

//--- cfg_store_if.sv
/*
 * Access channel between the register decoder and the priority settings store.
 * Assumes one write port and two asynchronous read ports on the same clock.
 */
`timescale 1ns/10ps
interface cfg_store_if #(
   parameter int IDX_W = 4,
   parameter int DATA_W = 8
);
   logic wr_en;
   logic [IDX_W-1:0] idx;
   logic [DATA_W-1:0] wdata;
   logic [DATA_W-1:0] rdata;
   logic [IDX_W-1:0] lk_idx;
   logic [DATA_W-1:0] lk_rdata;

   modport owner(output wr_en, idx, wdata, lk_idx, input rdata, lk_rdata);
   modport store(input wr_en, idx, wdata, lk_idx, output rdata, lk_rdata);
endinterface : cfg_store_if

//--- cfg_store.sv
/*
 * Settings array indexed by space, resource instance and partition.
 * Assumes the owner only writes indexes it has range-checked.
 */
`timescale 1ns/10ps
module cfg_store #(
   parameter int DEPTH = 16,
   parameter int IDX_W = 4,
   parameter int DATA_W = 8
) (
   input wire logic i_clk_sys,
   input wire logic i_arst_n,
   cfg_store_if.store io_cfg
);
   logic [DATA_W-1:0] mem_r [DEPTH];

   if (DEPTH > (1 << IDX_W) || DEPTH < 1) begin : g_bad_depth
      $error("cfg_store: DEPTH does not fit IDX_W");
   end

   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_r[i] <= '0;
         end
      end else if (io_cfg.wr_en && (int'(io_cfg.idx) < DEPTH)) begin
         mem_r[io_cfg.idx] <= io_cfg.wdata;
      end
   end

   assign io_cfg.rdata = (int'(io_cfg.idx) < DEPTH) ? mem_r[io_cfg.idx] : '0;
   assign io_cfg.lk_rdata = (int'(io_cfg.lk_idx) < DEPTH) ? mem_r[io_cfg.lk_idx] : '0;

endmodule : cfg_store

//--- capture_event_gen.sv
/*
 * Turns writes of the local capture trigger register into per-space capture pulses.
 * Assumes at most one register write per clock.
 */
`timescale 1ns/10ps
module capture_event_gen #(
   parameter bit PRESENT = 1'b1,
   parameter bit REALM_EXT = 1'b1
) (
   input wire logic i_clk_sys,
   input wire logic i_arst_n,
   input wire logic i_wr,
   input prio_capt_pkg::space_t i_space,
   input wire logic [1:0] i_wdata,
   output logic [prio_capt_pkg::NUM_SPACES-1:0] o_space_evt
);
   import prio_capt_pkg::*;

   logic [NUM_SPACES-1:0] evt_r;
   logic [NUM_SPACES-1:0] evt_nxt;
   logic [NUM_SPACES-1:0] targets;
   logic frame_live;
   logic fire;
   logic bcast;

   assign frame_live = (i_space == SPACE_SECURE) || (i_space == SPACE_NONSECURE) || REALM_EXT;
   assign fire = PRESENT && i_wr && frame_live && i_wdata[CAPT_FIRE_BIT];
   assign bcast = i_wdata[CAPT_BCAST_BIT] && (i_space != SPACE_NONSECURE);

   // Bit n of targets is the space whose code is n
   always_comb begin
      targets = '0;
      case (i_space)
         SPACE_SECURE: targets = bcast ? 4'h3 : 4'h1;
         SPACE_NONSECURE: targets = 4'h2;
         SPACE_ROOT: targets = bcast ? 4'hf : 4'h4;
         SPACE_REALM: targets = bcast ? 4'ha : 4'h8;
         default: targets = '0;
      endcase
   end

   assign evt_nxt = fire ? targets : '0;

   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         evt_r <= '0;
      end else begin
         evt_r <= evt_nxt;
      end
   end

   assign o_space_evt = evt_r;

endmodule : capture_event_gen

//--- partition_priority_capture_regs.sv
/*
 * Per-space register frames: partition selector, priority settings, capture trigger,
 * monitor selector and storage usage monitor control, with error status.
 * Assumes a single-cycle request port on i_clk_sys; answer one cycle later.
 */
`timescale 1ns/10ps
module partition_priority_capture_regs #(
   parameter bit HAS_PRI = 1'b1,
   parameter bit RESOURCE_SELECT_PRESENT = 1'b1,
   parameter bit HAS_NRW = 1'b1,
   parameter bit MONITORING_PRESENT = 1'b1,
   parameter bit HAS_LOCAL_TRIG = 1'b1,
   parameter bit HAS_CSU = 1'b1,
   parameter bit REALM_EXT = 1'b1,
   parameter int NUM_PARTITION_IDENTIFIER = 16,
   parameter int NUM_RIS = 2,
   parameter int NUM_MON = 2,
   parameter int DOWNSTREAM_PRIORITY_WD = 4,
   parameter int INTERNAL_PRIORITY_WD = 4
) (
   input wire logic i_clk_sys,
   input wire logic i_arst_n,
   input wire logic i_req_valid,
   input wire logic i_req_write,
   input prio_capt_pkg::space_t i_req_space,
   input wire logic [prio_capt_pkg::OFFSET_W-1:0] i_req_offset,
   input wire logic [31:0] i_req_wdata,
   output logic o_rsp_valid,
   output logic [31:0] o_rsp_rdata,
   input prio_capt_pkg::space_t i_lookup_space,
   input wire logic [prio_capt_pkg::SEL_RIS_W-1:0] i_lookup_ris,
   input wire logic [prio_capt_pkg::SEL_ID_W-1:0] i_lookup_partition_identifier,
   output logic [prio_capt_pkg::PRI_FIELD_W-1:0] o_lookup_downstream_priority,
   output logic [prio_capt_pkg::PRI_FIELD_W-1:0] o_lookup_internal_priority,
   output logic [prio_capt_pkg::NUM_SPACES-1:0] o_space_capture,
   output logic [prio_capt_pkg::NUM_SPACES*NUM_RIS*NUM_MON-1:0] o_mon_capture,
   output logic [prio_capt_pkg::NUM_SPACES*NUM_RIS*NUM_MON-1:0] o_mon_enable
);
   import prio_capt_pkg::*;

   localparam int PART_W = (NUM_PARTITION_IDENTIFIER > 1) ? $clog2(NUM_PARTITION_IDENTIFIER) : 1;
   localparam int RIS_IW = (NUM_RIS > 1) ? $clog2(NUM_RIS) : 1;
   localparam int MON_IW = (NUM_MON > 1) ? $clog2(NUM_MON) : 1;
   localparam int PRI_W = DOWNSTREAM_PRIORITY_WD + INTERNAL_PRIORITY_WD;
   localparam int PRI_IDX_W = 2 + RIS_IW + PART_W;
   localparam int PRI_DEPTH = NUM_SPACES * (1 << RIS_IW) * (1 << PART_W);
   localparam int MON_TOTAL = NUM_SPACES * NUM_RIS * NUM_MON;
   localparam int MON_IDX_W = 2 + RIS_IW + MON_IW;
   localparam logic [31:0] PART_SEL_MASK = {4'h0, (RESOURCE_SELECT_PRESENT ? 4'hf : 4'h0), 7'h00, HAS_NRW, 16'hffff};
   localparam logic [31:0] MONITOR_INDEX_MASK = {4'h0, (RESOURCE_SELECT_PRESENT ? 4'hf : 4'h0), 8'h00, 16'hffff};

   if (DOWNSTREAM_PRIORITY_WD < 1 || DOWNSTREAM_PRIORITY_WD > PRI_FIELD_W || INTERNAL_PRIORITY_WD < 1 || INTERNAL_PRIORITY_WD > PRI_FIELD_W) begin : g_bad_widths
      $error("partition_priority_capture_regs: priority widths out of range");
   end

   if (NUM_PARTITION_IDENTIFIER < 1 || NUM_PARTITION_IDENTIFIER > (1 << SEL_ID_W)) begin : g_bad_partitions
      $error("partition_priority_capture_regs: partition count out of range");
   end

   if (NUM_RIS < 1 || NUM_RIS > (1 << SEL_RIS_W) || NUM_MON < 1 || NUM_MON > (1 << SEL_ID_W)) begin : g_bad_counts
      $error("partition_priority_capture_regs: instance or monitor count out of range");
   end

   // Per-space selector and error state
   logic [31:0] part_sel_r [NUM_SPACES];
   logic [31:0] monitor_index_r [NUM_SPACES];
   logic [1:0] err_r [NUM_SPACES];
   logic [5:0] csu_r [MON_TOTAL];
   logic rsp_valid_r;
   logic [31:0] rsp_rdata_r;
   logic [PRI_FIELD_W-1:0] lk_ds_r;
   logic [PRI_FIELD_W-1:0] lk_int_r;
   logic [MON_TOTAL-1:0] mon_capt_r;
   logic [NUM_SPACES-1:0] space_evt;

   // Request decode
   logic frame_live;
   logic hit_err;
   logic hit_part_sel;
   logic hit_pri;
   logic hit_monitor_index;
   logic hit_capt;
   logic hit_csu;
   logic wr;

   assign frame_live = (i_req_space == SPACE_SECURE) || (i_req_space == SPACE_NONSECURE) || REALM_EXT;
   assign wr = i_req_valid && i_req_write && frame_live;
   assign hit_err = i_req_valid && frame_live && (i_req_offset == OFF_ERR_STATUS);
   assign hit_part_sel = i_req_valid && frame_live && (i_req_offset == OFF_PART_SEL);
   assign hit_pri = i_req_valid && frame_live && HAS_PRI && (i_req_offset == OFF_PRI);
   assign hit_monitor_index = i_req_valid && frame_live && MONITORING_PRESENT && (i_req_offset == OFF_MONITOR_INDEX);
   assign hit_capt = i_req_valid && frame_live && (i_req_offset == OFF_CAPT);
   assign hit_csu = i_req_valid && frame_live && MONITORING_PRESENT && HAS_CSU && (i_req_offset == OFF_CSU_CTL);

   // Priority store addressing through this space's partition selector
   logic [31:0] cur_part_sel;
   logic [SEL_RIS_W-1:0] sel_ris;
   logic [SEL_ID_W-1:0] sel_partition_identifier;
   logic internal_ok;
   logic part_range_ok;
   logic pri_access_ok;
   logic [PRI_IDX_W-1:0] pri_idx;
   logic [PRI_W-1:0] pri_wdata;
   logic [31:0] pri_rdata;

   assign cur_part_sel = part_sel_r[i_req_space];
   assign sel_ris = RESOURCE_SELECT_PRESENT ? cur_part_sel[SEL_RIS_LSB +: SEL_RIS_W] : '0;
   assign sel_partition_identifier = cur_part_sel[SEL_ID_W-1:0];
   assign internal_ok = !HAS_NRW || cur_part_sel[SEL_INTERNAL_BIT];
   assign part_range_ok = (32'(sel_partition_identifier) < NUM_PARTITION_IDENTIFIER) && (32'(sel_ris) < NUM_RIS);
   assign pri_access_ok = hit_pri && internal_ok && part_range_ok;
   assign pri_idx = {i_req_space, sel_ris[RIS_IW-1:0], sel_partition_identifier[PART_W-1:0]};
   assign pri_wdata = {i_req_wdata[PRI_DS_LSB +: DOWNSTREAM_PRIORITY_WD], i_req_wdata[INTERNAL_PRIORITY_WD-1:0]};

   cfg_store_if #(.IDX_W(PRI_IDX_W), .DATA_W(PRI_W)) pri_if ();

   assign pri_if.wr_en = pri_access_ok && wr;
   assign pri_if.idx = pri_idx;
   assign pri_if.wdata = pri_wdata;
   // Lookups beyond the implemented partitions or instances must not alias a real entry
   logic lk_range_ok;
   logic [SEL_RIS_W-1:0] lk_ris;
   logic [PRI_W-1:0] lk_settings;

   assign lk_ris = RESOURCE_SELECT_PRESENT ? i_lookup_ris : '0;
   assign lk_range_ok = (32'(i_lookup_partition_identifier) < NUM_PARTITION_IDENTIFIER) && (32'(lk_ris) < NUM_RIS);
   assign pri_if.lk_idx = {i_lookup_space, lk_ris[RIS_IW-1:0], i_lookup_partition_identifier[PART_W-1:0]};
   assign lk_settings = lk_range_ok ? pri_if.lk_rdata : '0;

   cfg_store #(.DEPTH(PRI_DEPTH), .IDX_W(PRI_IDX_W), .DATA_W(PRI_W)) u_pri_store (
      .i_clk_sys(i_clk_sys),
      .i_arst_n(i_arst_n),
      .io_cfg(pri_if.store)
   );

   // Implemented widths sit in the low bits of each half
   assign pri_rdata = {(PRI_FIELD_W)'(pri_if.rdata[PRI_W-1:INTERNAL_PRIORITY_WD]),
                       (PRI_FIELD_W)'(pri_if.rdata[INTERNAL_PRIORITY_WD-1:0])};

   // Monitor addressing through this space's monitor selector
   logic [31:0] cur_monitor_index;
   logic [SEL_RIS_W-1:0] mon_ris;
   logic [SEL_ID_W-1:0] mon_num;
   logic mon_range_ok;
   logic [MON_IDX_W-1:0] mon_idx;
   logic [5:0] csu_cur;
   logic [31:0] csu_rdata;

   assign cur_monitor_index = monitor_index_r[i_req_space];
   assign mon_ris = RESOURCE_SELECT_PRESENT ? cur_monitor_index[SEL_RIS_LSB +: SEL_RIS_W] : '0;
   assign mon_num = cur_monitor_index[SEL_ID_W-1:0];
   assign mon_range_ok = (32'(mon_num) < NUM_MON) && (32'(mon_ris) < NUM_RIS);
   assign mon_idx = MON_IDX_W'((32'(i_req_space) * NUM_RIS + 32'(mon_ris)) * NUM_MON + 32'(mon_num));
   assign csu_cur = mon_range_ok ? csu_r[mon_idx] : '0;
   assign csu_rdata = {csu_cur[5], csu_cur[4:2], 10'h000, csu_cur[1], csu_cur[0], 8'h00, CSU_TYPE_CODE};

   // Monitor control keeps enable, source select and the two match bits
   logic [5:0] csu_wdata;

   assign csu_wdata = {i_req_wdata[CSU_EN_BIT], i_req_wdata[CSU_CAPT_LSB +: 3],
                       i_req_wdata[CSU_MATCH_PMG_BIT], i_req_wdata[CSU_MATCH_PART_BIT]};

   // Local capture trigger
   capture_event_gen #(.PRESENT(MONITORING_PRESENT && HAS_LOCAL_TRIG), .REALM_EXT(REALM_EXT)) u_capt (
      .i_clk_sys(i_clk_sys),
      .i_arst_n(i_arst_n),
      .i_wr(hit_capt && i_req_write),
      .i_space(i_req_space),
      .i_wdata(i_req_wdata[1:0]),
      .o_space_evt(space_evt)
   );

   // Selector writes keep only the implemented fields
   logic part_sel_wr;
   logic monitor_index_wr;
   logic [31:0] part_sel_wdata;
   logic [31:0] monitor_index_wdata;

   assign part_sel_wr = hit_part_sel && wr;
   assign monitor_index_wr = hit_monitor_index && wr;
   assign part_sel_wdata = i_req_wdata & PART_SEL_MASK;
   assign monitor_index_wdata = i_req_wdata & MONITOR_INDEX_MASK;

   // Error status: write-one clears, and a fault raised in the same cycle stays set
   logic [1:0] err_clr;
   logic [1:0] err_set;
   logic [1:0] err_nxt;
   logic err_upd;

   assign err_clr = (hit_err && wr) ? i_req_wdata[1:0] : 2'h0;
   assign err_set[ERR_INTERNAL_BIT] = hit_pri && !internal_ok;
   assign err_set[ERR_RANGE_BIT] = hit_pri && internal_ok && !part_range_ok;
   assign err_nxt = (err_r[i_req_space] & ~err_clr) | err_set;
   assign err_upd = (hit_err && wr) || hit_pri;

   // Selectors and error status
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         for (int s = 0; s < NUM_SPACES; s++) begin
            part_sel_r[s] <= SEL_RST;
            monitor_index_r[s] <= SEL_RST;
            err_r[s] <= ERR_RST;
         end
      end else begin
         if (part_sel_wr) begin
            part_sel_r[i_req_space] <= part_sel_wdata;
         end
         if (monitor_index_wr) begin
            monitor_index_r[i_req_space] <= monitor_index_wdata;
         end
         if (err_upd) begin
            err_r[i_req_space] <= err_nxt;
         end
      end
   end

   // Monitor control storage and capture fan-out
   for (genvar g = 0; g < MON_TOTAL; g++) begin : g_mon
      localparam int G_SPACE = g / (NUM_RIS * NUM_MON);
      logic sel_me;
      assign sel_me = hit_csu && wr && mon_range_ok && (int'(mon_idx) == g);

      always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
         if (!i_arst_n) begin
            csu_r[g] <= CSU_RST;
            mon_capt_r[g] <= 1'b0;
         end else begin
            if (sel_me) begin
               csu_r[g] <= csu_wdata;
            end
            mon_capt_r[g] <= space_evt[G_SPACE] && (csu_r[g][4:2] == CAPT_SRC_LOCAL);
         end
      end

      assign o_mon_enable[g] = csu_r[g][5];
   end

   // Read data selection; a faulted priority access reads as zero
   logic [31:0] rd_data_nxt;
   logic [31:0] err_rdata;
   logic [31:0] pri_rd_value;

   assign err_rdata = {30'h0, err_r[i_req_space]};
   assign pri_rd_value = pri_access_ok ? pri_rdata : 32'h0000_0000;
   assign rd_data_nxt = !frame_live || i_req_write ? 32'h0000_0000 :
                        hit_err ? err_rdata :
                        hit_part_sel ? cur_part_sel :
                        hit_pri ? pri_rd_value :
                        hit_monitor_index ? cur_monitor_index :
                        hit_csu ? csu_rdata :
                        32'h0000_0000;

   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rsp_valid_r <= 1'b0;
         rsp_rdata_r <= '0;
         lk_ds_r <= '0;
         lk_int_r <= '0;
      end else begin
         rsp_valid_r <= i_req_valid;
         rsp_rdata_r <= rd_data_nxt;
         lk_ds_r <= (PRI_FIELD_W)'(lk_settings[PRI_W-1:INTERNAL_PRIORITY_WD]);
         lk_int_r <= (PRI_FIELD_W)'(lk_settings[INTERNAL_PRIORITY_WD-1:0]);
      end
   end

   assign o_rsp_valid = rsp_valid_r;
   assign o_rsp_rdata = rsp_rdata_r;
   assign o_lookup_downstream_priority = lk_ds_r;
   assign o_lookup_internal_priority = lk_int_r;
   assign o_space_capture = space_evt;
   assign o_mon_capture = mon_capt_r;

endmodule : partition_priority_capture_regs

//--- prio_capt_checker.sv
/*
 * Concurrent checks on the ports of the priority and capture trigger register block.
 * Assumes one clock, asynchronous active-low reset, and the default build parameters.
 */
`timescale 1ns/10ps
module prio_capt_checker #(
   parameter int NUM_RIS = 2,
   parameter int NUM_MON = 2
) (
   input wire logic i_clk_sys,
   input wire logic i_arst_n,
   input wire logic i_req_valid,
   input wire logic i_req_write,
   input prio_capt_pkg::space_t i_req_space,
   input wire logic [prio_capt_pkg::OFFSET_W-1:0] i_req_offset,
   input wire logic [31:0] i_req_wdata,
   input wire logic o_rsp_valid,
   input wire logic [31:0] o_rsp_rdata,
   input wire logic [prio_capt_pkg::NUM_SPACES-1:0] o_space_capture,
   input wire logic [prio_capt_pkg::NUM_SPACES*NUM_RIS*NUM_MON-1:0] o_mon_capture
);
   import prio_capt_pkg::*;

   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_arst_n);

   wire logic trig_wr = i_req_valid && i_req_write && (i_req_offset == OFF_CAPT);
   wire logic fire = trig_wr && i_req_wdata[CAPT_FIRE_BIT];
   wire logic bcast = i_req_wdata[CAPT_BCAST_BIT];
   wire logic capt_rd = i_req_valid && !i_req_write && (i_req_offset == OFF_CAPT);

   property p_space_evt(space_t sp, logic [3:0] with_all, logic [3:0] alone);
      fire && (i_req_space == sp) |=> o_space_capture == ($past(bcast) ? with_all : alone);
   endproperty

   a_rsp_one_cycle: assert property (i_req_valid |=> o_rsp_valid)
      else $error("no response one cycle after request");
   a_rsp_no_spurious: assert property (!i_req_valid |=> !o_rsp_valid)
      else $error("response without request");
   a_write_rdata_zero: assert property (i_req_valid && i_req_write |=> o_rsp_rdata == 32'h0000_0000)
      else $error("write response carries data");
   a_trig_reads_zero: assert property (capt_rd |=> o_rsp_rdata == 32'h0000_0000)
      else $error("trigger register read not zero");
   a_fire_zero_quiet: assert property (trig_wr && !i_req_wdata[0] |=> o_space_capture == 4'h0)
      else $error("event without fire bit");
   a_secure_fanout: assert property (p_space_evt(SPACE_SECURE, 4'h3, 4'h1))
      else $error("secure trigger fanout wrong");
   a_nonsec_fanout: assert property (p_space_evt(SPACE_NONSECURE, 4'h2, 4'h2))
      else $error("non-secure trigger fanout wrong");
   a_root_fanout: assert property (p_space_evt(SPACE_ROOT, 4'hf, 4'h4))
      else $error("root trigger fanout wrong");
   a_realm_fanout: assert property (p_space_evt(SPACE_REALM, 4'ha, 4'h8))
      else $error("realm trigger fanout wrong");
   a_event_has_cause: assert property (o_space_capture != 4'h0 |-> $past(fire))
      else $error("space event without trigger write");
   a_mon_follows_space: assert property (o_mon_capture != '0 |-> $past(o_space_capture) != 4'h0)
      else $error("monitor capture without space event");

   c_root_all: cover property (fire && bcast && i_req_space == SPACE_ROOT);
   c_mon_capture: cover property (o_mon_capture != '0);
   c_pri_read: cover property (i_req_valid && !i_req_write && i_req_offset == OFF_PRI);
endmodule : prio_capt_checker

bind partition_priority_capture_regs prio_capt_checker #(.NUM_RIS(NUM_RIS), .NUM_MON(NUM_MON)) u_chk (
   .i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_req_valid(i_req_valid), .i_req_write(i_req_write),
   .i_req_space(i_req_space), .i_req_offset(i_req_offset), .i_req_wdata(i_req_wdata),
   .o_rsp_valid(o_rsp_valid), .o_rsp_rdata(o_rsp_rdata), .o_space_capture(o_space_capture),
   .o_mon_capture(o_mon_capture));

//--- partition_priority_capture_regs_tb_top.sv
/*
 * Self-checking bench for the priority and capture trigger register block.
 * Assumes default build parameters: 16 partitions, 2 instances, 2 monitors, 4-bit priorities.
 */
`timescale 1ns/10ps
module partition_priority_capture_regs_tb_top;
   import prio_capt_pkg::*;
   `define CHK(got, exp, msg) begin checks++; if ((got) !== (exp)) begin error_cnt++; \
      $display("wrong value at %0t ns: %s", $time, msg); end end

   logic i_clk_sys, i_arst_n, i_req_valid, i_req_write, o_rsp_valid;
   space_t i_req_space, i_lookup_space;
   logic [11:0] i_req_offset;
   logic [31:0] i_req_wdata, o_rsp_rdata;
   logic [3:0] i_lookup_ris, o_space_capture;
   logic [15:0] i_lookup_partition_identifier, o_lookup_downstream_priority, o_lookup_internal_priority, o_mon_capture, o_mon_enable;
   int error_cnt = 0;
   int checks = 0;

   partition_priority_capture_regs dut (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n),
      .i_req_valid(i_req_valid), .i_req_write(i_req_write), .i_req_space(i_req_space),
      .i_req_offset(i_req_offset), .i_req_wdata(i_req_wdata), .o_rsp_valid(o_rsp_valid),
      .o_rsp_rdata(o_rsp_rdata), .i_lookup_space(i_lookup_space), .i_lookup_ris(i_lookup_ris),
      .i_lookup_partition_identifier(i_lookup_partition_identifier), .o_lookup_downstream_priority(o_lookup_downstream_priority), .o_lookup_internal_priority(o_lookup_internal_priority),
      .o_space_capture(o_space_capture), .o_mon_capture(o_mon_capture), .o_mon_enable(o_mon_enable));

   always #4 i_clk_sys = ~i_clk_sys;

   task automatic close_out();
      if (error_cnt == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : close_out

   // One request, held for exactly the taking edge; answer looked at just after it
   task automatic acc(input logic wr, input space_t sp, input logic [11:0] off, input logic [31:0] wd,
                      output logic [31:0] rd);
      @(posedge i_clk_sys);
      i_req_valid <= 1'b1;
      i_req_write <= wr;
      i_req_space <= sp;
      i_req_offset <= off;
      i_req_wdata <= wd;
      @(posedge i_clk_sys);
      i_req_valid <= 1'b0;
      #1;
      rd = o_rsp_rdata;
      `CHK(o_rsp_valid, 1'b1, "response strobe")
      if (wr) `CHK(rd, 32'h0000_0000, "write response data")
   endtask : acc

   task automatic wr(input space_t sp, input logic [11:0] off, input logic [31:0] wd);
      logic [31:0] rd;
      acc(1'b1, sp, off, wd, rd);
   endtask : wr

   task automatic rd_chk(input space_t sp, input logic [11:0] off, input logic [31:0] exp, input string msg);
      logic [31:0] rd;
      acc(1'b0, sp, off, 32'h0000_0000, rd);
      `CHK(rd, exp, msg)
   endtask : rd_chk

   task automatic t_priority();
      for (int s = 0; s < 4; s++) begin
         wr(space_t'(s), OFF_PART_SEL, 32'h0101_0003);
         wr(space_t'(s), OFF_PRI, 32'hfff0_fff8 | (32'(s) * 32'h0001_0001));
      end
      wr(SPACE_SECURE, OFF_PART_SEL, 32'h0001_0003);
      wr(SPACE_SECURE, OFF_PRI, 32'h000e_000e);
      rd_chk(SPACE_SECURE, OFF_PRI, 32'h000e_000e, "instance 0 priority");
      for (int s = 0; s < 4; s++) begin
         wr(space_t'(s), OFF_PART_SEL, 32'h0101_0003);
         rd_chk(space_t'(s), OFF_PRI, 32'h0000_0008 | (32'(s) * 32'h0001_0001),
                "space priority");
      end
      @(posedge i_clk_sys);
      i_lookup_space <= SPACE_REALM;
      i_lookup_ris <= 4'h1;
      i_lookup_partition_identifier <= 16'h0003;
      repeat (2) @(posedge i_clk_sys);
      #1;
      `CHK(o_lookup_downstream_priority, 16'h0003, "lookup downstream")
      `CHK(o_lookup_internal_priority, 16'h000b, "lookup internal")
      @(posedge i_clk_sys);
      i_lookup_ris <= 4'h2;
      repeat (2) @(posedge i_clk_sys);
      #1;
      `CHK(o_lookup_internal_priority, 16'h0000, "lookup beyond instances")
   endtask : t_priority

   task automatic t_internal();
      wr(SPACE_NONSECURE, OFF_PART_SEL, 32'h0100_0003);
      wr(SPACE_NONSECURE, OFF_PRI, 32'h0000_0000);
      rd_chk(SPACE_NONSECURE, OFF_PRI, 32'h0000_0000, "flag-error read");
      rd_chk(SPACE_NONSECURE, OFF_ERR_STATUS, 32'h0000_0001, "error recorded");
      wr(SPACE_NONSECURE, OFF_ERR_STATUS, 32'h0000_0001);
      rd_chk(SPACE_NONSECURE, OFF_ERR_STATUS, 32'h0000_0000, "error cleared");
      wr(SPACE_NONSECURE, OFF_PART_SEL, 32'h0101_0003);
      rd_chk(SPACE_NONSECURE, OFF_PRI, 32'h0001_0009, "setting kept");
   endtask : t_internal

   task automatic t_trigger();
      logic [3:0] exp_tab [4][4] = '{'{4'h0, 4'h1, 4'h0, 4'h3}, '{4'h0, 4'h2, 4'h0, 4'h2},
                                     '{4'h0, 4'h4, 4'h0, 4'hf}, '{4'h0, 4'h8, 4'h0, 4'ha}};
      logic [3:0] e;
      wr(SPACE_SECURE, OFF_MONITOR_INDEX, 32'h0000_0001);
      wr(SPACE_SECURE, OFF_CSU_CTL, 32'hf000_0000);
      rd_chk(SPACE_SECURE, OFF_CSU_CTL, 32'hf000_0043, "monitor control");
      wr(SPACE_NONSECURE, OFF_MONITOR_INDEX, 32'h0100_0000);
      wr(SPACE_NONSECURE, OFF_CSU_CTL, 32'hf000_0000);
      `CHK(o_mon_enable, 16'h0042, "monitor enables")
      for (int s = 0; s < 4; s++) begin
         for (int w = 0; w < 4; w++) begin
            e = exp_tab[s][w];
            wr(space_t'(s), OFF_CAPT, 32'hffff_fffc | 32'(w));
            `CHK(o_space_capture, e, "space capture")
            @(posedge i_clk_sys);
            #1;
            `CHK(o_mon_capture, {9'h000, e[1], 4'h0, e[0], 1'b0}, "monitor capture")
            `CHK(o_space_capture, 4'h0, "single pulse")
            rd_chk(space_t'(s), OFF_CAPT, 32'h0000_0000, "trigger read");
         end
      end
   endtask : t_trigger

   task automatic t_unmapped();
      wr(SPACE_SECURE, 12'h7fc, 32'hffff_ffff);
      rd_chk(SPACE_SECURE, 12'h7fc, 32'h0000_0000, "unmapped read");
   endtask : t_unmapped

   initial begin
      i_clk_sys = 1'b0;
      i_arst_n = 1'b0;
      i_req_valid = 1'b0;
      i_req_write = 1'b0;
      i_req_space = SPACE_SECURE;
      i_req_offset = 12'h000;
      i_req_wdata = 32'h0000_0000;
      i_lookup_space = SPACE_SECURE;
      i_lookup_ris = 4'h0;
      i_lookup_partition_identifier = 16'h0000;
      repeat (10) @(posedge i_clk_sys);
      i_arst_n <= 1'b1;
      t_priority();
      t_internal();
      t_trigger();
      t_unmapped();
      close_out();
   end

   initial begin
      repeat (20000) @(posedge i_clk_sys);
      error_cnt++;
      close_out();
   end
endmodule : partition_priority_capture_regs_tb_top
